// ### dac_i2c_pkg.sv
// shared constants for the two-wire dac code port
`default_nettype none
package dac_i2c_pkg;
   // slave address: upper five bits fixed, two low bits ignored
   localparam logic [6:0] SLAVE_ADDR = 7'h0C;
   localparam logic [6:0] SLAVE_ADDR_MASK = 7'h7C;
   // input word field positions
   localparam int POWER_DOWN_POS = 15;
   localparam int CODE_MSB_POS = 13;
   localparam int CODE_LSB_POS = 4;
   localparam int CODE_W = CODE_MSB_POS - CODE_LSB_POS + 1;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int DATA_BYTES = 2;
   // values after reset
   localparam logic [15:0] INPUT_WORD_RST = 16'h0000;
   localparam logic [9:0] DAC_CODE_RST = 10'h000;
   // timing: system clock and fastest serial clock
   localparam int SYS_CLK_HZ = 50_000_000;
   localparam int SCL_MAX_HZ = 400_000;
   localparam int SCL_PERIOD_CYC = SYS_CLK_HZ / SCL_MAX_HZ;
   localparam int SYNC_STAGES = 2;
   // serial engine states, gray along the write path
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b011,
      ST_WRITE = 3'b010,
      ST_READ = 3'b110,
      ST_READ_ACK = 3'b111,
      ST_IGNORE = 3'b100
   } engine_state_e;
endpackage : dac_i2c_pkg
`default_nettype wire

// ### pin_sync.sv
// two-flop synchroniser with edge detection for one bus pin
`default_nettype none
module pin_sync #(
   parameter int STAGES = 2,
   parameter logic IDLE_LEVEL = 1'b1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // pin and synchronised view
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic [STAGES-1:0] sync_reg;
   logic prev_reg;

   // a single stage would let a metastable sample reach the logic
   if (STAGES < 2) begin : g_bad_stages
      $error("pin_sync needs at least two stages");
   end

   // the first stage is read only by the next stage
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_reg <= {STAGES{IDLE_LEVEL}};
      end else begin
         sync_reg <= {sync_reg[STAGES-2:0], pin_i};
      end
   end

   // one more flop so edges compare two settled samples
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_reg <= IDLE_LEVEL;
      end else begin
         prev_reg <= sync_reg[STAGES-1];
      end
   end

   assign level_o = sync_reg[STAGES-1];
   assign rise_o = sync_reg[STAGES-1] & ~prev_reg;
   assign fall_o = ~sync_reg[STAGES-1] & prev_reg;
endmodule : pin_sync
`default_nettype wire

// ### dac_i2c_port.sv
// two-wire slave port that loads the 10-bit dac code register
// Summary of operation
// - address 0001100, two low bits ignored
// - detect start, then shift eight bits
// - eighth bit: 0 write, 1 read
// - ack: drive low before ninth pulse
// - acknowledge a matching address and the first two write data bytes; no later data byte and no read byte
// - exactly two data bytes per transaction; a lone data byte is still acknowledged and loads the high byte only
// - write high byte first, msb first
// - after both bytes, copy to dac register
// - bit 15 is active-high soft power-down
// - bits 13..4 form the dac code
// - read returns same order as write
// - after read, clear holding register
// - works up to 400 kHz serial clock
// - only pull data low, else release
`default_nettype none
module dac_i2c_port
   import dac_i2c_pkg::*;
(
   // system clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // two-wire bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // converter controls
   output logic [CODE_W-1:0] dac_code_o,
   output logic soft_power_down_o,
   output logic [WORD_W-1:0] input_word_o,
   output logic bus_busy_o
);
   // several system clocks per serial half period are needed
   if (SCL_PERIOD_CYC < 16) begin : g_slow_clk
      $error("system clock too slow for bus");
   end

   logic scl_lvl;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic sda_rise;
   logic sda_fall;
   logic start_det;
   logic stop_det;

   engine_state_e state_reg;
   logic [3:0] bit_cnt_reg;
   logic [BYTE_W-1:0] shift_reg;
   logic byte_idx_reg;
   logic read_dir_reg;
   logic read_seen_reg;
   logic pull_low_reg;
   logic [WORD_W-1:0] input_word_reg;
   logic [CODE_W-1:0] dac_code_reg;
   logic power_down_reg;
   logic write_full_reg;
   logic busy_reg;
   logic byte_full;

   // address compare ignoring the two low bits
   function automatic logic addr_hit(input logic [6:0] addr);
      addr_hit = (addr & SLAVE_ADDR_MASK) == (SLAVE_ADDR & SLAVE_ADDR_MASK);
   endfunction : addr_hit

   // serial bit of the outgoing byte for the given position
   function automatic logic tx_bit(input logic [WORD_W-1:0] word,
                                   input logic idx,
                                   input logic [3:0] pos);
      logic [BYTE_W-1:0] b;
      b = idx ? word[7:0] : word[15:8];
      tx_bit = b[3'(7 - pos)];
   endfunction : tx_bit

   // both pins pass two flops before any logic looks at them
   pin_sync #(.STAGES(SYNC_STAGES), .IDLE_LEVEL(1'b1)) u_scl_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .pin_i(scl_i),
      .level_o(scl_lvl),
      .rise_o(scl_rise),
      .fall_o(scl_fall)
   );

   pin_sync #(.STAGES(SYNC_STAGES), .IDLE_LEVEL(1'b1)) u_sda_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .pin_i(sda_i),
      .level_o(sda_lvl),
      .rise_o(sda_rise),
      .fall_o(sda_fall)
   );

   // data edges while clock high are frame markers; legal data only
   // moves while clock is low, so no other edge can look like one
   assign start_det = sda_fall & scl_lvl;
   assign stop_det = sda_rise & scl_lvl;
   assign byte_full = bit_cnt_reg == 4'd8;

   // serial engine
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
      end else if (start_det) begin
         state_reg <= ST_ADDR;
      end else if (stop_det) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_ADDR: begin
               if (scl_fall && byte_full) begin
                  if (addr_hit(shift_reg[7:1])) begin
                     state_reg <= ST_ADDR_ACK;
                  end else begin
                     state_reg <= ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  state_reg <= read_dir_reg ? ST_READ : ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (scl_fall && byte_full) begin
                  state_reg <= ST_ADDR_ACK;
               end
            end
            ST_READ: begin
               if (scl_fall && byte_full) begin
                  state_reg <= ST_READ_ACK;
               end
            end
            ST_READ_ACK: begin
               // master nack or both bytes gone: stand off until stop
               if (scl_rise && (sda_lvl || byte_idx_reg)) begin
                  state_reg <= ST_IGNORE;
               end else if (scl_fall) begin
                  state_reg <= ST_READ;
               end
            end
            ST_IDLE: state_reg <= ST_IDLE;
            ST_IGNORE: state_reg <= ST_IGNORE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // bit counter: counts clock rises within a byte
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_reg <= 4'd0;
      end else if (start_det || (scl_fall && byte_full)) begin
         bit_cnt_reg <= 4'd0;
      end else if (scl_rise && (state_reg == ST_ADDR ||
               state_reg == ST_WRITE || state_reg == ST_READ)) begin
         bit_cnt_reg <= bit_cnt_reg + 4'd1;
      end
   end

   // receive shifter, msb first, sampled on clock rise
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_reg <= 8'h00;
      end else if (scl_rise && !byte_full &&
                   (state_reg == ST_ADDR || state_reg == ST_WRITE)) begin
         shift_reg <= {shift_reg[6:0], sda_lvl};
      end
   end

   // direction bit is the eighth bit of the address byte
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_dir_reg <= 1'b0;
      end else if (state_reg == ST_ADDR && scl_fall && byte_full) begin
         read_dir_reg <= shift_reg[0];
      end
   end

   // data byte index, plus a marker once a whole word is in, so that
   // a third write byte can be told apart from the second
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byte_idx_reg <= 1'b0;
         write_full_reg <= 1'b0;
      end else if (start_det) begin
         byte_idx_reg <= 1'b0;
         write_full_reg <= 1'b0;
      end else if (scl_fall && ((state_reg == ST_WRITE && byte_full) ||
                  state_reg == ST_READ_ACK)) begin
         byte_idx_reg <= 1'b1;
         write_full_reg <= state_reg == ST_WRITE && byte_idx_reg;
      end
   end

   // an acknowledged read address is remembered until the frame closes
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_seen_reg <= 1'b0;
      end else if (state_reg == ST_ADDR_ACK && read_dir_reg) begin
         read_seen_reg <= 1'b1;
      end else if (start_det || stop_det) begin
         read_seen_reg <= 1'b0;
      end
   end

   // open-drain data drive: low or released, changed on clock fall
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pull_low_reg <= 1'b0;
      end else if (start_det || stop_det) begin
         pull_low_reg <= 1'b0;
      end else if (scl_fall) begin
         case (state_reg)
            ST_ADDR: begin
               pull_low_reg <= byte_full && addr_hit(shift_reg[7:1]);
            end
            ST_WRITE: begin
               // a third data byte is not acknowledged
               pull_low_reg <= byte_full && !write_full_reg;
            end
            ST_ADDR_ACK: begin
               pull_low_reg <= read_dir_reg &&
                  !tx_bit(input_word_reg, byte_idx_reg, 4'd0);
            end
            ST_READ: begin
               pull_low_reg <= !byte_full &&
                  !tx_bit(input_word_reg, byte_idx_reg, bit_cnt_reg);
            end
            ST_READ_ACK: begin
               pull_low_reg <= !tx_bit(input_word_reg, 1'b1, 4'd0);
            end
            default: pull_low_reg <= 1'b0;
         endcase
      end else if (state_reg == ST_IGNORE) begin
         pull_low_reg <= 1'b0;
      end
   end

   // holding register: fills on write, clears once a read closes
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         input_word_reg <= INPUT_WORD_RST;
      end else if (read_seen_reg && (start_det || stop_det)) begin
         input_word_reg <= INPUT_WORD_RST;
      end else if (state_reg == ST_WRITE && scl_fall && byte_full &&
                   !write_full_reg) begin
         if (byte_idx_reg) begin
            input_word_reg[7:0] <= shift_reg;
         end else begin
            input_word_reg[15:8] <= shift_reg;
         end
      end
   end

   // dac register loads once the second data byte is in
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dac_code_reg <= DAC_CODE_RST;
         power_down_reg <= 1'b0;
      end else if (state_reg == ST_WRITE && scl_fall && byte_full &&
                   byte_idx_reg && !write_full_reg) begin
         dac_code_reg <= {input_word_reg[CODE_MSB_POS:BYTE_W],
            shift_reg[BYTE_W-1:CODE_LSB_POS]};
         power_down_reg <= input_word_reg[POWER_DOWN_POS];
      end
   end

   // bus busy between start and stop
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_reg <= 1'b0;
      end else if (start_det) begin
         busy_reg <= 1'b1;
      end else if (stop_det) begin
         busy_reg <= 1'b0;
      end
   end

   // the pin value is always low; only the enable moves
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~pull_low_reg;
   assign dac_code_o = dac_code_reg;
   assign soft_power_down_o = power_down_reg;
   assign input_word_o = input_word_reg;
   assign bus_busy_o = busy_reg;
endmodule : dac_i2c_port
`default_nettype wire

// ### dac_i2c_port_properties.sv
// pin-level checks for the two-wire dac code port
`default_nettype none
module dac_i2c_port_properties
   import dac_i2c_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   // converter side
   input wire logic [CODE_W-1:0] dac_code_o,
   input wire logic soft_power_down_o,
   input wire logic [WORD_W-1:0] input_word_o,
   input wire logic bus_busy_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // value pin stays low, only the enable moves
   a_sda_only_low: assert property (sda_o == 1'b0)
      else $error("data pin value high");
   a_reset_zero: assert property ($rose(rst_n_i) |->
      input_word_o == 16'h0000 && dac_code_o == 10'h000)
      else $error("outputs not clear after reset");
   a_code_field: assert property ($changed(dac_code_o) |->
      dac_code_o == input_word_o[CODE_MSB_POS:CODE_LSB_POS])
      else $error("code not taken from word");
   a_power_down_field: assert property ($changed(soft_power_down_o) |->
      soft_power_down_o == input_word_o[POWER_DOWN_POS])
      else $error("power-down not word msb");
   // the device moves data only while the clock is low
   a_ack_clk_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
      else $error("data moved with clock high");
   a_drive_busy: assert property (!sda_oe_n_o |-> bus_busy_o)
      else $error("data driven outside a frame");
   a_start_busy: assert property (scl_i && $fell(sda_i) &&
      !bus_busy_o |-> ##[1:8] bus_busy_o)
      else $error("start not seen");
   a_stop_idle: assert property (scl_i && $rose(sda_i)
      |-> ##[1:8] !bus_busy_o)
      else $error("stop not seen");
   // dac only loads inside a frame
   a_dac_idle: assert property (!bus_busy_o && !$past(bus_busy_o)
      |-> $stable(dac_code_o) && $stable(soft_power_down_o))
      else $error("dac moved while idle");
   c_ack: cover property ($fell(sda_oe_n_o));
   c_load: cover property ($changed(dac_code_o));
   c_clear: cover property ($rose(input_word_o == 16'h0000));
endmodule : dac_i2c_port_properties
bind dac_i2c_port dac_i2c_port_properties u_props (.clk_sys_i, .rst_n_i,
   .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .dac_code_o, .soft_power_down_o,
   .input_word_o, .bus_busy_o);
`default_nettype wire

// ### i2c_master_model.sv
// behavioural two-wire bus master driving the dac code port
`default_nettype none
module i2c_master_model #(
   parameter int QTR_CYC = 32
) (
   // clock that paces the bus phases
   input wire logic clk_sys_i,
   // device enable on the open-drain data line
   input wire logic dev_oe_n_i,
   // bus wires
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pull_low = 1'b0;
   initial scl_o = 1'b1;
   // pull-up: a released line reads high, never a stale value
   assign sda_o = (dev_oe_n_i === 1'b0 || pull_low) ? 1'b0 : 1'b1;
   // quarter period keeps the clock just under the fastest legal rate
   task automatic qtr();
      repeat (QTR_CYC) @(posedge clk_sys_i);
   endtask : qtr
   // start or repeated start
   task automatic start();
      qtr();
      pull_low <= 1'b0;
      qtr();
      scl_o <= 1'b1;
      qtr();
      pull_low <= 1'b1;
      qtr();
      scl_o <= 1'b0;
   endtask : start
   task automatic stop();
      qtr();
      pull_low <= 1'b1;
      qtr();
      scl_o <= 1'b1;
      qtr();
      pull_low <= 1'b0;
      qtr();
   endtask : stop
   // data set mid low phase, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      qtr();
      pull_low <= !b;
      qtr();
      scl_o <= 1'b1;
      qtr();
      r = sda_o;
      qtr();
      scl_o <= 1'b0;
   endtask : bit_io
   task automatic byte_io(input logic [7:0] tx, input logic ack_tx,
         output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ack_tx, ack_rx);
   endtask : byte_io
endmodule : i2c_master_model
`default_nettype wire

// ### dac_i2c_port_tb.sv
// self-checking bench for the two-wire dac code port
`default_nettype none
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin \
   n_errors++; $display("ERROR %0t got %0h want %0h", $time, g, w); end end
module dac_i2c_port_tb
   import dac_i2c_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic scl, sda, sda_o, sda_oe_n_o, soft_power_down_o, bus_busy_o, ack;
   logic [CODE_W-1:0] dac_code_o;
   logic [WORD_W-1:0] input_word_o;
   logic [WORD_W-1:0] exp_word = 16'h0000;
   logic [CODE_W-1:0] exp_dac = 10'h000;
   logic exp_power_down = 1'b0;
   logic [7:0] rx;
   logic [15:0] words [4] = '{16'hBFFF, 16'h400F, 16'h8010, 16'h3AC5};
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   dac_i2c_port u_dut (.clk_sys_i, .rst_n_i, .scl_i(scl), .sda_i(sda),
      .sda_o, .sda_oe_n_o, .dac_code_o, .soft_power_down_o, .input_word_o,
      .bus_busy_o);
   i2c_master_model u_master (.clk_sys_i, .dev_oe_n_i(sda_oe_n_o),
      .scl_o(scl), .sda_o(sda));
   always #10 clk_sys_i = ~clk_sys_i;
   // a hung frame ends the run as a failure
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic chk_out();
      `CHK(input_word_o, exp_word)
      `CHK(dac_code_o, exp_dac)
      `CHK(soft_power_down_o, exp_power_down)
      `CHK({bus_busy_o, sda_oe_n_o}, 2'b01)
   endtask : chk_out
   // n data bytes; a third one must be refused
   task automatic t_write(input logic [6:0] a, input logic [15:0] w,
         input int n);
      logic [7:0] b [3];
      b = '{w[15:8], w[7:0], 8'h5A};
      u_master.start();
      u_master.byte_io({a, 1'b0}, 1'b1, rx, ack);
      `CHK(ack, 1'b0)
      for (int i = 0; i < n; i++) begin
         u_master.byte_io(b[i], 1'b1, rx, ack);
         `CHK(ack, i > 1)
      end
      u_master.stop();
      if (n > 0)
         exp_word[15:8] = w[15:8];
      if (n > 1) begin
         exp_word = w;
         exp_dac = w[CODE_MSB_POS:CODE_LSB_POS];
         exp_power_down = w[POWER_DOWN_POS];
      end
      chk_out();
   endtask : t_write
   task automatic t_bad(input logic [6:0] a);
      u_master.start();
      u_master.byte_io({a, 1'b0}, 1'b1, rx, ack);
      `CHK(ack, 1'b1)
      u_master.byte_io(8'h00, 1'b1, rx, ack);
      `CHK(ack, 1'b1)
      u_master.stop();
      chk_out();
   endtask : t_bad
   // read back both bytes, then the word must be clear
   task automatic t_read();
      u_master.start();
      u_master.byte_io({SLAVE_ADDR, 1'b1}, 1'b1, rx, ack);
      `CHK(ack, 1'b0)
      u_master.byte_io(8'hFF, 1'b0, rx, ack);
      `CHK(rx, exp_word[15:8])
      u_master.byte_io(8'hFF, 1'b1, rx, ack);
      `CHK(rx, exp_word[7:0])
      u_master.stop();
      exp_word = 16'h0000;
      chk_out();
   endtask : t_read
   // mid-run reset while the bus idles: everything back to clear
   task automatic t_reset();
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      exp_word = INPUT_WORD_RST;
      exp_dac = DAC_CODE_RST;
      exp_power_down = 1'b0;
      chk_out();
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      chk_out();
   endtask : t_reset
   initial begin
      repeat (5) @(posedge clk_sys_i);
      chk_out();
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      for (int i = 0; i < 4; i++)
         t_write(SLAVE_ADDR | 7'(i), words[i], 2);
      t_write(SLAVE_ADDR, 16'h1234, 1);
      t_read();
      t_bad(7'h10);
      t_bad(7'h0B);
      t_write(7'h0E, 16'h5555, 3);
      t_read();
      t_read();
      t_reset();
      t_write(SLAVE_ADDR, 16'hC3F0, 2);
      wrap_up();
   end
endmodule : dac_i2c_port_tb
`undef CHK
`default_nettype wire
